// ### core/ccri_channel.sv
// one channel of the counter relay interface: status words, request word and counter
`timescale 1ns/10ps
// Operation
// - ready-done bit set once parameters prepared and counting can start
// - enabled bit high while counting is enabled
// - direction bit 1 forward counting, 0 reverse counting
// - capture 0 done bit set when count latched into capture 0
// - capture 1 done bit set when count latched into capture 1
// - two monitor bits show driven state of external outputs
// - three monitor bits show state of A, B, Z inputs
// - two monitor bits show state of the two control inputs
// - overflow and underflow flags raised only in linear counter type
// - error flag stays set until rising edge on error-clear bit
// - second status word carries sixteen comparison match flags
// - host holds ready request high; channel recomputes parameters meanwhile
// - counting runs only while count-enable request is high
// - rising edge on reset request clears count; level has no effect
// - rising edge on preset request loads preset value into counter
// - Z reset acts only while reset-enable request high
// - rising edge on change request loads configured change value
// - rising edge on preset change request updates stored preset value
// - capture request is enable in edge mode, trigger in sampling mode
// - four level bits force external outputs on or off while held
// - rising edges clear overflow and underflow flags respectively
// - downloaded configuration takes effect only on ready request
module ccri_channel (
	input wire logic MCLK_I, // unit clock
	input wire logic RST_B_I, // async reset, active low
	input wire logic CE_I, // clock enable
	input wire logic [15:0] CHANNEL_REQUEST_WORD_I, // request relays from host
	input wire ccri_pkg::ccri_cfg_s CFG_I, // downloaded configuration
	input wire ccri_pkg::ccri_pins_s PINS_I, // raw pulse and control pins
	input wire logic [15:0] MATCH_I, // comparison results
	input wire logic [1:0] OUT_CMP_I, // comparison-driven external outputs
	input wire logic ERR_EVT_I, // error detected
	output logic [15:0] CHANNEL_STATUS_WORD_O, // status relays
	output logic [15:0] COMPARISON_MATCH_WORD_O, // match relays
	output logic [1:0] EXT_OUT_O, // external outputs 0 and 1
	output logic [31:0] COUNT_O, // current count
	output logic [31:0] CAPTURE0_O, // capture 0 register
	output logic [31:0] CAPTURE1_O // capture 1 register
);
	logic [15:0] req_reg;
	logic [15:0] req_prev_reg;
	logic [15:0] req_rise;
	ccri_pkg::ccri_cfg_s cfg_reg;
	ccri_pkg::ccri_pins_s s1_reg, s2_reg, s3_reg, pin_reg;
	logic ready_reg;
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic [31:0] preset_reg;
	logic [31:0] cap0_reg, cap1_reg;
	logic cap0_done_reg, cap1_done_reg;
	logic ovf_reg, unf_reg, err_reg;
	logic [1:0] out_reg;
	logic [15:0] match_reg;
	logic a_prev_reg, z_prev_reg, c0_prev_reg;
	logic count_step, z_reset, cap_edge_trig, cap_samp_trig;
	logic at_max, at_min, count_load;

	function automatic logic force_out(input logic cmp, input logic on, input logic off);
		if (off) begin
			return 1'b0;
		end
		return on | cmp;
	endfunction

	assign req_rise = req_reg & ~req_prev_reg;

	// request relays come from same-clock backplane logic
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			req_reg <= ccri_pkg::REQ_RESET;
			req_prev_reg <= ccri_pkg::REQ_RESET;
		end else if (CE_I) begin
			req_reg <= CHANNEL_REQUEST_WORD_I;
			req_prev_reg <= req_reg;
		end
	end

	// pins pass three flops; a change counts when second and third agree
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			pin_reg <= '0;
		end else if (CE_I) begin
			s1_reg <= PINS_I;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			pin_reg <= (s2_reg ~^ s3_reg) & s2_reg | ~(s2_reg ~^ s3_reg) & pin_reg;
		end
	end

	// configuration latched while ready request is held
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cfg_reg <= '0;
			ready_reg <= 1'b0;
		end else if (CE_I) begin
			if (req_reg[ccri_pkg::RQ_READY]) begin
				cfg_reg <= CFG_I;
			end
			ready_reg <= req_reg[ccri_pkg::RQ_READY];
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			a_prev_reg <= 1'b0;
			z_prev_reg <= 1'b0;
			c0_prev_reg <= 1'b0;
		end else if (CE_I) begin
			a_prev_reg <= pin_reg.in_a;
			z_prev_reg <= pin_reg.in_z;
			c0_prev_reg <= pin_reg.ctl0;
		end
	end

	assign count_step = ready_reg & req_reg[ccri_pkg::RQ_CNT_EN] & pin_reg.in_a & ~a_prev_reg;
	assign z_reset = req_reg[ccri_pkg::RQ_RST_EN] & pin_reg.in_z & ~z_prev_reg;
	assign at_max = count_reg == cfg_reg.upper;
	assign at_min = count_reg == cfg_reg.lower;
	assign count_load = req_rise[ccri_pkg::RQ_RESET] | req_rise[ccri_pkg::RQ_PRESET] | req_rise[ccri_pkg::RQ_CHG_CUR] | z_reset;

	// downloaded preset applies on ready; change request takes the current image
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			preset_reg <= ccri_pkg::CNT_RESET;
		end else if (CE_I) begin
			if (req_rise[ccri_pkg::RQ_CHG_PRE]) begin
				preset_reg <= cfg_reg.preset_val;
			end else if (req_rise[ccri_pkg::RQ_READY]) begin
				preset_reg <= CFG_I.preset_val;
			end
		end
	end

	always_comb begin
		count_next = count_reg;
		if (req_rise[ccri_pkg::RQ_RESET] || z_reset) begin
			count_next = ccri_pkg::CNT_RESET;
		end else if (req_rise[ccri_pkg::RQ_PRESET]) begin
			count_next = preset_reg;
		end else if (req_rise[ccri_pkg::RQ_CHG_CUR]) begin
			count_next = cfg_reg.change_val;
		end else if (count_step) begin
			if (!cfg_reg.reverse) begin
				count_next = (at_max && cfg_reg.ring) ? cfg_reg.lower : (at_max ? count_reg : count_reg + 32'h00000001);
			end else begin
				count_next = (at_min && cfg_reg.ring) ? cfg_reg.upper : (at_min ? count_reg : count_reg - 32'h00000001);
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			count_reg <= ccri_pkg::CNT_RESET;
		end else if (CE_I) begin
			count_reg <= count_next;
		end
	end

	// linear counter range flags; set wins over clear
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ovf_reg <= 1'b0;
			unf_reg <= 1'b0;
		end else if (CE_I) begin
			if (count_step && !cfg_reg.ring && !cfg_reg.reverse && at_max) begin
				ovf_reg <= 1'b1;
			end else if (req_rise[ccri_pkg::RQ_OVF_CLR]) begin
				ovf_reg <= 1'b0;
			end
			if (count_step && !cfg_reg.ring && cfg_reg.reverse && at_min) begin
				unf_reg <= 1'b1;
			end else if (req_rise[ccri_pkg::RQ_UNF_CLR]) begin
				unf_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			err_reg <= 1'b0;
		end else if (CE_I) begin
			if (ERR_EVT_I) begin
				err_reg <= 1'b1;
			end else if (req_rise[ccri_pkg::RQ_ERR_CLR]) begin
				err_reg <= 1'b0;
			end
		end
	end

	// capture 0: edge on ctl0 while enabled, or sample on request rise
	assign cap_edge_trig = cfg_reg.cap_mode == ccri_pkg::CCRI_CAP_EDGE && req_reg[ccri_pkg::RQ_CAPTURE]
		&& pin_reg.ctl0 && !c0_prev_reg;
	assign cap_samp_trig = cfg_reg.cap_mode == ccri_pkg::CCRI_CAP_SAMPLE && req_rise[ccri_pkg::RQ_CAPTURE];

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cap0_reg <= ccri_pkg::CNT_RESET;
			cap1_reg <= ccri_pkg::CNT_RESET;
			cap0_done_reg <= 1'b0;
			cap1_done_reg <= 1'b0;
		end else if (CE_I) begin
			// ready low clears done flags every cycle; a capture in the same cycle wins
			if (!ready_reg) begin
				cap0_done_reg <= 1'b0;
				cap1_done_reg <= 1'b0;
			end
			if (cap_edge_trig || cap_samp_trig) begin
				cap0_reg <= count_reg;
				cap0_done_reg <= 1'b1;
			end
			if (cap_edge_trig) begin
				cap1_reg <= count_reg;
				cap1_done_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			out_reg <= 2'h0;
		end else if (CE_I) begin
			out_reg[0] <= force_out(OUT_CMP_I[0], req_reg[ccri_pkg::RQ_O0_ON], req_reg[ccri_pkg::RQ_O0_OFF]);
			out_reg[1] <= force_out(OUT_CMP_I[1], req_reg[ccri_pkg::RQ_O1_ON], req_reg[ccri_pkg::RQ_O1_OFF]);
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			match_reg <= 16'h0000;
		end else if (CE_I) begin
			match_reg <= MATCH_I;
		end
	end

	always_comb begin
		CHANNEL_STATUS_WORD_O = 16'h0000;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_READY] = ready_reg;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_ENABLED] = ready_reg & req_reg[ccri_pkg::RQ_CNT_EN];
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_DIR] = ~cfg_reg.reverse;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_CAP0] = cap0_done_reg;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_CAP1] = cap1_done_reg;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_OUT0] = out_reg[0];
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_OUT1] = out_reg[1];
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_IN_A] = pin_reg.in_a;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_IN_B] = pin_reg.in_b;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_IN_Z] = pin_reg.in_z;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_CTL0] = pin_reg.ctl0;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_CTL1] = pin_reg.ctl1;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_OVF] = ovf_reg;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_UNF] = unf_reg;
		CHANNEL_STATUS_WORD_O[ccri_pkg::ST_ERR] = err_reg;
	end

	assign COMPARISON_MATCH_WORD_O = match_reg;
	assign EXT_OUT_O = out_reg;
	assign COUNT_O = count_reg;
	assign CAPTURE0_O = cap0_reg;
	assign CAPTURE1_O = cap1_reg;

	a_ready_follow: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I ##1 CE_I |-> CHANNEL_STATUS_WORD_O[ccri_pkg::ST_READY] == $past(req_reg[ccri_pkg::RQ_READY]))
		else $error("ready bit does not follow request");
	a_enable_gate: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		!req_reg[ccri_pkg::RQ_CNT_EN] |-> !count_step && !CHANNEL_STATUS_WORD_O[ccri_pkg::ST_ENABLED])
		else $error("counting without enable");
	a_reset_clears: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_RESET] |=> count_reg == ccri_pkg::CNT_RESET)
		else $error("reset request did not clear count");
	a_preset_loads: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_PRESET] && !req_rise[ccri_pkg::RQ_RESET] && !z_reset
		|=> count_reg == $past(preset_reg))
		else $error("preset not loaded");
	a_z_gated: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		!req_reg[ccri_pkg::RQ_RST_EN] |-> !z_reset)
		else $error("z reset while disabled");
	a_force_off: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_reg[ccri_pkg::RQ_O0_OFF] |=> !EXT_OUT_O[0])
		else $error("force off not honoured");
	a_force_on: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_reg[ccri_pkg::RQ_O1_ON] && !req_reg[ccri_pkg::RQ_O1_OFF] |=> EXT_OUT_O[1])
		else $error("force on not honoured");
	a_err_sticky: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		err_reg && !req_rise[ccri_pkg::RQ_ERR_CLR] |=> err_reg)
		else $error("error flag dropped without clear");
	a_ring_no_ovf: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		cfg_reg.ring && !ovf_reg |=> !ovf_reg)
		else $error("overflow raised in ring mode");
	a_ovf_clear: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_OVF_CLR] && !count_step |=> !ovf_reg)
		else $error("overflow not cleared");
	a_cfg_taken: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_reg[ccri_pkg::RQ_READY] |=> cfg_reg == $past(CFG_I))
		else $error("configuration not taken while ready held");
	a_cfg_held: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && !req_reg[ccri_pkg::RQ_READY] |=> cfg_reg == $past(cfg_reg))
		else $error("configuration changed without ready");
	a_preset_ready: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_READY] && !req_rise[ccri_pkg::RQ_CHG_PRE]
		|=> preset_reg == $past(CFG_I.preset_val))
		else $error("preset not taken on ready");
	a_preset_store: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_CHG_PRE] |=> preset_reg == $past(cfg_reg.preset_val))
		else $error("preset value not updated");
	a_change_loads: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_CHG_CUR] && !req_rise[ccri_pkg::RQ_RESET]
		&& !req_rise[ccri_pkg::RQ_PRESET] && !z_reset |=> count_reg == $past(cfg_reg.change_val))
		else $error("change value not loaded");
	a_z_resets: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_reg[ccri_pkg::RQ_RST_EN] && pin_reg.in_z && !z_prev_reg
		|=> count_reg == ccri_pkg::CNT_RESET)
		else $error("z edge did not reset count");
	a_count_up: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && count_step && !count_load && !cfg_reg.reverse && !at_max
		|=> count_reg == $past(count_reg) + 32'h00000001)
		else $error("forward step did not add one");
	a_count_down: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && count_step && !count_load && cfg_reg.reverse && !at_min
		|=> count_reg == $past(count_reg) - 32'h00000001)
		else $error("reverse step did not subtract one");
	a_count_hold: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && !count_step && !count_load |=> count_reg == $past(count_reg))
		else $error("count changed without step or load");
	a_ovf_set: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && count_step && !cfg_reg.ring && !cfg_reg.reverse && at_max |=> ovf_reg)
		else $error("overflow not raised");
	a_unf_set: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && count_step && !cfg_reg.ring && cfg_reg.reverse && at_min |=> unf_reg)
		else $error("underflow not raised");
	a_ring_no_unf: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		cfg_reg.ring && !unf_reg |=> !unf_reg)
		else $error("underflow raised in ring mode");
	a_unf_clear: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_UNF_CLR] && !count_step |=> !unf_reg)
		else $error("underflow not cleared");
	a_err_clear: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_rise[ccri_pkg::RQ_ERR_CLR] && !ERR_EVT_I |=> !err_reg)
		else $error("error flag not cleared");
	a_force_off1: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && req_reg[ccri_pkg::RQ_O1_OFF] |=> !EXT_OUT_O[1])
		else $error("force off of output 1 not honoured");
	a_match_copy: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I |=> COMPARISON_MATCH_WORD_O == $past(MATCH_I))
		else $error("match word does not follow results");
	a_cap0_latch: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && (cap_edge_trig || cap_samp_trig) |=> cap0_done_reg && CAPTURE0_O == $past(count_reg))
		else $error("capture 0 not latched");
	a_cap1_latch: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && cap_edge_trig |=> cap1_done_reg && CAPTURE1_O == $past(count_reg))
		else $error("capture 1 not latched");
	a_pin_filter: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		CE_I && s2_reg == s3_reg |=> pin_reg == $past(s2_reg))
		else $error("agreed pin level not taken");
endmodule

// ### core/ccri_pkg.sv
// package: layouts, field positions and reset values of the channel relay interface
package ccri_pkg;
	localparam int unsigned CNT_W = 32;
	// status word bit positions
	localparam int unsigned ST_READY = 0;
	localparam int unsigned ST_ENABLED = 1;
	localparam int unsigned ST_DIR = 2;
	localparam int unsigned ST_CAP0 = 4;
	localparam int unsigned ST_CAP1 = 5;
	localparam int unsigned ST_OUT0 = 6;
	localparam int unsigned ST_OUT1 = 7;
	localparam int unsigned ST_IN_A = 8;
	localparam int unsigned ST_IN_B = 9;
	localparam int unsigned ST_IN_Z = 10;
	localparam int unsigned ST_CTL0 = 11;
	localparam int unsigned ST_CTL1 = 12;
	localparam int unsigned ST_OVF = 13;
	localparam int unsigned ST_UNF = 14;
	localparam int unsigned ST_ERR = 15;
	// request word bit positions
	localparam int unsigned RQ_READY = 0;
	localparam int unsigned RQ_CNT_EN = 1;
	localparam int unsigned RQ_RESET = 2;
	localparam int unsigned RQ_PRESET = 3;
	localparam int unsigned RQ_RST_EN = 4;
	localparam int unsigned RQ_CHG_CUR = 5;
	localparam int unsigned RQ_CHG_PRE = 6;
	localparam int unsigned RQ_CAPTURE = 7;
	localparam int unsigned RQ_O0_ON = 9;
	localparam int unsigned RQ_O0_OFF = 10;
	localparam int unsigned RQ_O1_ON = 11;
	localparam int unsigned RQ_O1_OFF = 12;
	localparam int unsigned RQ_OVF_CLR = 13;
	localparam int unsigned RQ_UNF_CLR = 14;
	localparam int unsigned RQ_ERR_CLR = 15;
	localparam logic [15:0] REQ_RESET = 16'h0000;
	localparam logic [31:0] CNT_RESET = 32'h00000000;
	localparam logic [31:0] CNT_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] CNT_MIN = 32'h80000000;

	// configuration image downloaded by the host
	typedef struct packed {
		logic ring;
		logic reverse;
		logic [1:0] cap_mode;
		logic [31:0] preset_val;
		logic [31:0] change_val;
		logic [31:0] upper;
		logic [31:0] lower;
	} ccri_cfg_s;

	// pulse and control inputs of one channel
	typedef struct packed {
		logic in_a;
		logic in_b;
		logic in_z;
		logic ctl0;
		logic ctl1;
	} ccri_pins_s;

	// capture modes
	typedef enum logic [1:0] {
		CCRI_CAP_OFF,
		CCRI_CAP_EDGE,
		CCRI_CAP_SAMPLE
	} ccri_cap_e;
endpackage

// ### tb/ccri_host_model.sv
// host side model: owns the request relay word and changes it just after a clock edge
`timescale 1ns/10ps
module ccri_host_model (
	input wire logic MCLK_I, // unit clock
	output logic [15:0] REQ_O // request relays towards the channel
);
	initial REQ_O = ccri_pkg::REQ_RESET;
	// level bits stay where they are set until the host changes them
	task automatic put(input int unsigned pos, input logic val);
		@(posedge MCLK_I);
		#1;
		REQ_O[pos] = val;
	endtask
	// edge requests: one cycle high, then released
	task automatic pulse(input int unsigned pos);
		put(pos, 1'b1);
		put(pos, 1'b0);
	endtask
endmodule

// ### tb/counter_channel_relay_interface_tb_top.sv
// self-checking bench for one channel of the counter relay interface
`timescale 1ns/10ps
module counter_channel_relay_interface_tb_top;
	logic mclk;
	logic rst_b;
	ccri_pkg::ccri_cfg_s cfg;
	ccri_pkg::ccri_pins_s pins;
	logic [15:0] match;
	logic [1:0] out_cmp;
	logic err_evt;
	logic [15:0] req;
	logic [15:0] st;
	logic [15:0] mword;
	logic [1:0] ext;
	logic [31:0] cnt;
	logic [31:0] cap0;
	logic [31:0] cap1;
	int num_errors;
	int checks_done;
	int cycles;

	ccri_host_model host (.MCLK_I(mclk), .REQ_O(req));
	ccri_channel DUT (
		.MCLK_I(mclk), .RST_B_I(rst_b), .CE_I(1'b1), .CHANNEL_REQUEST_WORD_I(req), .CFG_I(cfg),
		.PINS_I(pins), .MATCH_I(match), .OUT_CMP_I(out_cmp), .ERR_EVT_I(err_evt),
		.CHANNEL_STATUS_WORD_O(st), .COMPARISON_MATCH_WORD_O(mword), .EXT_OUT_O(ext),
		.COUNT_O(cnt), .CAPTURE0_O(cap0), .CAPTURE1_O(cap1)
	);

	always #4 mclk = ~mclk;

	task automatic complete_run();
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			num_errors = num_errors + 1;
			complete_run();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chkb(input string name, input logic exp, input logic got);
		chk(name, {31'h00000000, exp}, {31'h00000000, got});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// pulses on input A, long enough to pass the synchroniser and filter
	task automatic step_a(input int n);
		repeat (n) begin
			pins.in_a = 1'b1;
			wt(5);
			pins.in_a = 1'b0;
			wt(5);
		end
	endtask
	task automatic load(input logic [31:0] v);
		cfg.change_val = v;
		wt(2);
		host.pulse(ccri_pkg::RQ_CHG_CUR);
		wt(3);
	endtask

	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		cfg = '0;
		pins = '0;
		match = 16'h0000;
		out_cmp = 2'h0;
		err_evt = 1'b0;
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		wt(4);
		rst_b = 1'b1;
		chk("status_rst", 32'h00000004, {16'h0000, st});
		cfg.preset_val = 32'h00000123;
		cfg.change_val = 32'h00000456;
		cfg.upper = ccri_pkg::CNT_MAX;
		cfg.lower = ccri_pkg::CNT_MIN;
		host.put(ccri_pkg::RQ_READY, 1'b1);
		wt(3);
		chkb("ready", 1'b1, st[ccri_pkg::ST_READY]);
		step_a(2);
		chk("count_disabled", 32'h00000000, cnt);
		host.put(ccri_pkg::RQ_CNT_EN, 1'b1);
		wt(3);
		chkb("enabled", 1'b1, st[ccri_pkg::ST_ENABLED]);
		step_a(3);
		chk("count_up", 32'h00000003, cnt);
		cfg.reverse = 1'b1;
		wt(3);
		chkb("dir_rev", 1'b0, st[ccri_pkg::ST_DIR]);
		step_a(1);
		chk("count_down", 32'h00000002, cnt);
		cfg.reverse = 1'b0;
		host.put(ccri_pkg::RQ_RESET, 1'b1);
		wt(3);
		chk("count_reset", 32'h00000000, cnt);
		step_a(2);
		chk("reset_level", 32'h00000002, cnt);
		host.put(ccri_pkg::RQ_RESET, 1'b0);
		host.pulse(ccri_pkg::RQ_PRESET);
		wt(3);
		chk("preset", 32'h00000123, cnt);
		host.pulse(ccri_pkg::RQ_CHG_CUR);
		wt(3);
		chk("change", 32'h00000456, cnt);
		cfg.preset_val = 32'h00000789;
		wt(2);
		host.pulse(ccri_pkg::RQ_CHG_PRE);
		host.pulse(ccri_pkg::RQ_PRESET);
		wt(3);
		chk("preset_changed", 32'h00000789, cnt);
		host.put(ccri_pkg::RQ_READY, 1'b0);
		wt(1);
		cfg.reverse = 1'b1;
		wt(3);
		chkb("cfg_held", 1'b1, st[ccri_pkg::ST_DIR]);
		host.put(ccri_pkg::RQ_READY, 1'b1);
		wt(3);
		chkb("cfg_taken", 1'b0, st[ccri_pkg::ST_DIR]);
		cfg.reverse = 1'b0;
		load(ccri_pkg::CNT_MAX);
		step_a(1);
		chkb("ovf", 1'b1, st[ccri_pkg::ST_OVF]);
		chk("count_max", ccri_pkg::CNT_MAX, cnt);
		host.pulse(ccri_pkg::RQ_OVF_CLR);
		wt(3);
		chkb("ovf_clr", 1'b0, st[ccri_pkg::ST_OVF]);
		cfg.reverse = 1'b1;
		load(ccri_pkg::CNT_MIN);
		step_a(1);
		chkb("unf", 1'b1, st[ccri_pkg::ST_UNF]);
		host.pulse(ccri_pkg::RQ_UNF_CLR);
		wt(3);
		chkb("unf_clr", 1'b0, st[ccri_pkg::ST_UNF]);
		cfg.ring = 1'b1;
		step_a(1);
		chkb("unf_ring", 1'b0, st[ccri_pkg::ST_UNF]);
		cfg.ring = 1'b0;
		cfg.reverse = 1'b0;
		err_evt = 1'b1;
		wt(1);
		err_evt = 1'b0;
		wt(8);
		chkb("err_held", 1'b1, st[ccri_pkg::ST_ERR]);
		host.pulse(ccri_pkg::RQ_ERR_CLR);
		wt(3);
		chkb("err_clr", 1'b0, st[ccri_pkg::ST_ERR]);
		for (int k = 0; k < 2; k++) begin
			out_cmp[k] = 1'b1;
			wt(3);
			chkb("out_cmp", 1'b1, ext[k]);
			host.put(ccri_pkg::RQ_O0_OFF + 2 * k, 1'b1);
			wt(3);
			chkb("out_off", 1'b0, ext[k]);
			host.put(ccri_pkg::RQ_O0_ON + 2 * k, 1'b1);
			wt(3);
			chkb("out_both", 1'b0, ext[k]);
			host.put(ccri_pkg::RQ_O0_OFF + 2 * k, 1'b0);
			out_cmp[k] = 1'b0;
			wt(3);
			chkb("out_on", 1'b1, ext[k]);
			chkb("out_mon", 1'b1, st[ccri_pkg::ST_OUT0 + k]);
			host.put(ccri_pkg::RQ_O0_ON + 2 * k, 1'b0);
			wt(3);
			chkb("out_mon_off", 1'b0, st[ccri_pkg::ST_OUT0 + k]);
		end
		host.put(ccri_pkg::RQ_CNT_EN, 1'b0);
		pins = 5'b10101;
		wt(6);
		chk("pins_a", 32'h00000015, {27'h0000000, st[12:8]});
		chk("z_blocked", ccri_pkg::CNT_MAX, cnt);
		pins = 5'b01011;
		wt(6);
		chk("pins_b", 32'h0000001A, {27'h0000000, st[12:8]});
		match = 16'hA5C3;
		wt(3);
		chk("match", 32'h0000A5C3, {16'h0000, mword});
		host.put(ccri_pkg::RQ_RST_EN, 1'b1);
		pins.in_z = 1'b1;
		wt(6);
		chk("z_reset", 32'h00000000, cnt);
		host.put(ccri_pkg::RQ_RST_EN, 1'b0);
		pins = '0;
		cfg.cap_mode = ccri_pkg::CCRI_CAP_EDGE;
		load(32'h00000321);
		host.put(ccri_pkg::RQ_CAPTURE, 1'b1);
		wt(2);
		pins.ctl0 = 1'b1;
		wt(8);
		chkb("cap0_done", 1'b1, st[ccri_pkg::ST_CAP0]);
		chkb("cap1_done", 1'b1, st[ccri_pkg::ST_CAP1]);
		chk("cap0", 32'h00000321, cap0);
		chk("cap1", 32'h00000321, cap1);
		host.put(ccri_pkg::RQ_CAPTURE, 1'b0);
		host.put(ccri_pkg::RQ_READY, 1'b0);
		pins.ctl0 = 1'b0;
		cfg.cap_mode = ccri_pkg::CCRI_CAP_SAMPLE;
		wt(3);
		host.put(ccri_pkg::RQ_READY, 1'b1);
		load(32'h00000654);
		chkb("cap0_idle", 1'b0, st[ccri_pkg::ST_CAP0]);
		host.put(ccri_pkg::RQ_CAPTURE, 1'b1);
		wt(4);
		chk("cap0_sample", 32'h00000654, cap0);
		complete_run();
	end
endmodule
